// ---- hw/sync_micro_port.sv ----
// clock-synchronous 8-bit microprocessor port with two handshake modes
`default_nettype none

module sync_micro_port (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            portMode,
  input  wire logic                            chipSel_n,
  input  wire logic                            dataStrobe_n,
  input  wire logic                            writeLine,
  input  wire logic [micro_port_pkg::ADDR_W-1:0] addr,
  input  wire logic [micro_port_pkg::DATA_W-1:0] dataIn,
  output logic      [micro_port_pkg::DATA_W-1:0] dataOut,
  output logic                                 dataOe_n,
  output logic                                 ready,
  output logic                                 transferAck_n,
  output logic                                 accStrobe,
  output logic                                 accWrite,
  output logic      [micro_port_pkg::ADDR_W-1:0] accAddr,
  output logic      [micro_port_pkg::DATA_W-1:0] accWrData,
  input  wire logic [micro_port_pkg::DATA_W-1:0] accRdData
);

  // ==========================================================================
  // state
  typedef struct packed {
    micro_port_pkg::port_state_t          state;
    logic                                 isWrite;
    logic [micro_port_pkg::ADDR_W-1:0]    addr;
    logic [micro_port_pkg::DATA_W-1:0]    wrData;
    logic [micro_port_pkg::DATA_W-1:0]    rdData;
    logic                                 strobe;
    logic                                 ackN;
    logic                                 oeN;
  } port_regs_t;

  port_regs_t                         st_reg;
  port_regs_t                         st_next;
  logic                               rdReq;
  logic                               wrReq;
  logic                               start;
  logic                               expired;
  logic [micro_port_pkg::LAT_W-1:0]   latency;

  // ==========================================================================
  // request decode, all sampled on clk
  always_comb begin
    if (portMode == micro_port_pkg::MODE_DATASTROBE) begin
      rdReq = !dataStrobe_n && writeLine;
      wrReq = !dataStrobe_n && !writeLine;
    end else begin
      rdReq = !dataStrobe_n;
      wrReq = !writeLine;
    end
    // the next access is accepted on any edge in idle
    start = (st_reg.state == micro_port_pkg::ST_IDLE) && !chipSel_n
            && (rdReq || wrReq);
    // both strobes low in mode 0 is a host fault; read wins
    if (!rdReq) begin
      latency = portMode ? micro_port_pkg::WR_LAT_MODE1
                         : micro_port_pkg::WR_LAT_MODE0;
    end else if (addr == micro_port_pkg::INTERNAL_ADDR) begin
      latency = micro_port_pkg::RD_LAT_INTERNAL;
    end else begin
      latency = micro_port_pkg::RD_LAT_OTHER;
    end
  end

  port_wait_counter waitCounter (
    .clk       (clk),
    .rst_n     (rst_n),
    .load      (start),
    .loadValue (latency),
    .expired   (expired)
  );

  // ==========================================================================
  // access sequencer
  always_comb begin
    st_next        = st_reg;
    st_next.strobe = 1'h0;
    unique case (st_reg.state)
      micro_port_pkg::ST_IDLE: begin
        if (start) begin
          st_next.state   = micro_port_pkg::ST_BUSY;
          st_next.isWrite = !rdReq;
          st_next.addr    = addr;
          st_next.wrData  = dataIn;
          st_next.strobe  = 1'h1;
          st_next.oeN     = !rdReq;
        end
      end
      micro_port_pkg::ST_BUSY: begin
        if (expired) begin
          st_next.state  = micro_port_pkg::ST_DONE;
          st_next.rdData = accRdData;
          st_next.ackN   = !portMode;
        end
        if (chipSel_n) begin
          st_next.oeN = 1'h1;
        end
      end
      micro_port_pkg::ST_DONE: begin
        if (chipSel_n) begin
          st_next.state = micro_port_pkg::ST_IDLE;
          st_next.ackN  = 1'h1;
          st_next.oeN   = 1'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.state   <= micro_port_pkg::ST_IDLE;
      st_reg.isWrite <= 1'h0;
      st_reg.addr    <= micro_port_pkg::ADDR_RESET;
      st_reg.wrData  <= micro_port_pkg::DATA_RESET;
      st_reg.rdData  <= micro_port_pkg::DATA_RESET;
      st_reg.strobe  <= 1'h0;
      st_reg.ackN    <= 1'h1;
      st_reg.oeN     <= 1'h1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // outputs
  // ready must fall without a clock edge, so it alone is gated from pins
  assign ready = portMode || chipSel_n || (dataStrobe_n && writeLine)
                 || (st_reg.state == micro_port_pkg::ST_DONE);
  assign transferAck_n = st_reg.ackN;
  assign dataOut       = st_reg.rdData;
  assign dataOe_n      = st_reg.oeN;
  assign accStrobe     = st_reg.strobe;
  assign accWrite      = st_reg.isWrite;
  assign accAddr       = st_reg.addr;
  assign accWrData     = st_reg.wrData;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence waitThree;
    ##1 (st_reg.state == micro_port_pkg::ST_BUSY) [*3]
    ##1 (st_reg.state == micro_port_pkg::ST_DONE);
  endsequence

  sequence waitTwo;
    ##1 (st_reg.state == micro_port_pkg::ST_BUSY) [*2]
    ##1 (st_reg.state == micro_port_pkg::ST_DONE);
  endsequence

  rd_internal_wait_a: assert property (
    start && !portMode && rdReq && (addr == micro_port_pkg::INTERNAL_ADDR)
    |-> waitThree ##0 ready)
    else $error("mode 0 internal read ready not at third edge");

  rd_other_wait_a: assert property (
    start && !portMode && rdReq && (addr != micro_port_pkg::INTERNAL_ADDR)
    |-> waitTwo)
    else $error("mode 0 read ready not at second edge");

  wr_ready_wait_a: assert property (
    start && !portMode && !rdReq |-> waitTwo)
    else $error("mode 0 write ready not at second edge");

  rd_ack_timing_a: assert property (
    start && portMode && (addr == micro_port_pkg::INTERNAL_ADDR)
    |-> ##1 transferAck_n [*3] ##1 !transferAck_n)
    else $error("mode 1 acknowledge timing wrong for address zero");

  wr_ack_timing_a: assert property (
    start && portMode && !rdReq
    |-> ##1 transferAck_n [*3] ##1 !transferAck_n)
    else $error("mode 1 write acknowledge not at third edge");

  ready_pull_low_a: assert property (
    !portMode && !chipSel_n && (rdReq || wrReq)
    && (st_reg.state != micro_port_pkg::ST_DONE) |-> !ready)
    else $error("ready not pulled low during access");

  ack_release_a: assert property (
    (st_reg.state == micro_port_pkg::ST_DONE) && chipSel_n
    |=> transferAck_n && (st_reg.state == micro_port_pkg::ST_IDLE))
    else $error("access not ended when chip select sampled high");

  bus_drive_read_a: assert property (
    !dataOe_n |-> !st_reg.isWrite
    && (st_reg.state != micro_port_pkg::ST_IDLE) && !$past(chipSel_n))
    else $error("data bus driven outside a read");

  mode_inert_a: assert property (
    (portMode |-> ready) and (!portMode |-> transferAck_n))
    else $error("handshake of the unused mode active");

  // a non-internal read in mode 1 acknowledges one edge sooner
  sequence ackTwo;
    ##1 transferAck_n [*2] ##1 !transferAck_n;
  endsequence

  rd_other_ack_a: assert property (
    start && portMode && rdReq && (addr != micro_port_pkg::INTERNAL_ADDR)
    |-> ackTwo)
    else $error("mode 1 acknowledge not at second edge");

  access_capture_a: assert property (
    start |=> accStrobe && (accAddr == $past(addr))
    && (accWrite == !$past(rdReq)) && (accWrData == $past(dataIn)))
    else $error("access not captured at the start edge");

  read_data_a: assert property (
    expired && !st_reg.isWrite |=> (dataOut == $past(accRdData)))
    else $error("read data not taken at the completion edge");

  ack_hold_a: assert property (
    portMode && (st_reg.state == micro_port_pkg::ST_DONE) && !chipSel_n
    |=> !transferAck_n)
    else $error("acknowledge dropped before chip select rose");

  // the driver may lag chip select by one cycle, never by more
  bus_release_a: assert property (
    chipSel_n && (st_reg.state != micro_port_pkg::ST_IDLE) |=> dataOe_n)
    else $error("data bus still driven after chip select rose");

endmodule // sync_micro_port

`default_nettype wire

// ---- hw/micro_port_pkg.sv ----
// constants and types shared by the synchronous microprocessor port
// Operation
// - mode pin low: read and write strobes, ready output, clock-sampled
// - mode pin high: data strobe, read/write line, acknowledge, clock-sampled
// - mode 0: ready pulled low combinationally by chip select and strobe
// - mode 0 read: ready released at edge three for address 000, else two
// - mode 0 write: ready released at the second edge for any address
// - next write may start on the edge after completion
// - mode 1 read: acknowledge low at edge three for address 000, else two
// - mode 1 read ends and acknowledge rises when chip select sampled high
// - mode 1 write: acknowledge low at the third edge
// - mode 1 write completes, acknowledge rises, when chip select sampled high
`default_nettype none

package micro_port_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int LAT_W  = 2;

  // ==========================================================================
  // access states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BUSY = 3'h2,
    ST_DONE = 3'h4
  } port_state_t;

  // ==========================================================================
  // addresses, modes, latencies in clock edges after the start edge
  localparam logic [ADDR_W-1:0] INTERNAL_ADDR   = 3'h0;
  localparam logic              MODE_STROBES    = 1'h0;
  localparam logic              MODE_DATASTROBE = 1'h1;
  localparam logic [LAT_W-1:0]  RD_LAT_INTERNAL = 2'h3;
  localparam logic [LAT_W-1:0]  RD_LAT_OTHER    = 2'h2;
  localparam logic [LAT_W-1:0]  WR_LAT_MODE0    = 2'h2;
  localparam logic [LAT_W-1:0]  WR_LAT_MODE1    = 2'h3;
  localparam logic [LAT_W-1:0]  LAT_LAST        = 2'h1;
  localparam logic [DATA_W-1:0] DATA_RESET      = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET      = 3'h0;

endpackage

`default_nettype wire

// ---- hw/port_wait_counter.sv ----
// down counter that times the wait of one port access
`default_nettype none

module port_wait_counter (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           load,
  input  wire logic [micro_port_pkg::LAT_W-1:0] loadValue,
  output logic                                expired
);

  typedef struct packed {
    logic [micro_port_pkg::LAT_W-1:0] count;
  } counter_state_t;

  counter_state_t cur_reg;
  counter_state_t cur_next;

  always_comb begin
    cur_next = cur_reg;
    if (load) begin
      cur_next.count = loadValue;
    end else if (cur_reg.count != '0) begin
      cur_next.count = cur_reg.count - micro_port_pkg::LAT_LAST;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // the last count is seen on the edge that must end the wait
  assign expired = !load && (cur_reg.count == micro_port_pkg::LAT_LAST);

endmodule // port_wait_counter

`default_nettype wire

// ---- tb/host_model.sv ----
// host bus master model driving the microprocessor port pins
`default_nettype none

module host_model (
  input  wire logic       clk,
  input  wire logic       ready,
  input  wire logic       transferAck_n,
  input  wire logic       dataOe_n,
  input  wire logic [7:0] dataOut,
  output var  logic       chipSel_n,
  output var  logic       dataStrobe_n,
  output var  logic       writeLine,
  output var  logic [2:0] addr,
  output var  logic [7:0] dataIn
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    chipSel_n = 1'b1;
    dataStrobe_n = 1'b1;
    writeLine = 1'b1;
    addr = 3'h0;
    dataIn = 8'h00;
  end

  // ==========================================================================
  // one access, entered at a rising edge; lat counts edges after the start
  task automatic xfer(input logic md, wr, input logic [2:0] a,
    input logic [7:0] d, output int lat, output logic [7:0] rd,
    output logic [3:0] flg);
    chipSel_n <= 1'b0;
    dataStrobe_n <= md ? 1'b0 : wr;
    writeLine <= !wr;
    addr <= a;
    dataIn <= d;
    #1 flg[3] = ready;
    lat = -1;
    do begin
      @(posedge clk);
      #1 lat++;
    end while (lat < 9 && (md ? transferAck_n : !ready));
    rd = dataOut;
    flg[2] = dataOe_n;
    @(posedge clk);
    // strobes stay asserted between accesses; lines released go inverted
    chipSel_n <= 1'b1;
    addr <= ~a;
    dataIn <= ~d;
    @(posedge clk);
    #1 flg[1] = transferAck_n;
    flg[0] = dataOe_n;
    // next access is driven after the edge after completion, so it starts one edge later
    @(posedge clk);
  endtask
endmodule // host_model

`default_nettype wire

// ---- tb/test_sync_microprocessor_port.sv ----
// self-checking bench for the synchronous microprocessor port
`default_nettype none

module test_sync_microprocessor_port;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        portMode = 1'b0;
  logic [7:0]  accRdData = 8'h00;
  logic        chipSel_n, dataStrobe_n, writeLine, dataOe_n, ready;
  logic        transferAck_n, accStrobe, accWrite;
  logic [2:0]  addr, accAddr, a;
  logic [7:0]  dataIn, dataOut, accWrData, d, rd;
  logic [3:0]  flg;
  logic [1:0]  exLat;
  logic        md, wr;
  logic [31:0] seed = 32'h28186770;
  logic [11:0] expQ[$];
  int          lat, miscompares = 0, numChecks = 0, cyc = 0;

  always #5 clk = ~clk;

  sync_micro_port DUT (.clk(clk), .rst_n(rst_n), .portMode(portMode),
    .chipSel_n(chipSel_n), .dataStrobe_n(dataStrobe_n),
    .writeLine(writeLine), .addr(addr), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe_n(dataOe_n), .ready(ready),
    .transferAck_n(transferAck_n), .accStrobe(accStrobe),
    .accWrite(accWrite), .accAddr(accAddr), .accWrData(accWrData),
    .accRdData(accRdData));

  host_model host (.clk(clk), .ready(ready), .transferAck_n(transferAck_n),
    .dataOe_n(dataOe_n), .dataOut(dataOut), .chipSel_n(chipSel_n),
    .dataStrobe_n(dataStrobe_n), .writeLine(writeLine), .addr(addr),
    .dataIn(dataIn));

  // ==========================================================================
  // checking and closing
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // internal access pulse is registered, so it is sampled mid-cycle
  always @(negedge clk) begin
    if (accStrobe === 1'b1) begin
      if (expQ.size() == 0) begin
        chk(12'hFFF, 12'h000);
      end else begin
        chk({accWrite, accAddr, accWrData & {8{accWrite}}},
            expQ.pop_front());
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end

  // ==========================================================================
  // every mode, direction and internal or other address, back to back
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      md = i[3];
      // reads then writes in a row, so the held strobes are exercised
      wr = i[2];
      seed = lfsr(seed);
      a = (i[1:0] == 2'h0) ? micro_port_pkg::INTERNAL_ADDR : seed[2:0];
      d = seed[15:8];
      portMode <= md;
      accRdData <= seed[23:16];
      expQ.push_back({wr, a, wr ? d : 8'h00});
      exLat = wr ? (md ? micro_port_pkg::WR_LAT_MODE1
                       : micro_port_pkg::WR_LAT_MODE0)
                 : (a == micro_port_pkg::INTERNAL_ADDR
                    ? micro_port_pkg::RD_LAT_INTERNAL
                    : micro_port_pkg::RD_LAT_OTHER);
      host.xfer(md, wr, a, d, lat, rd, flg);
      chk(12'(lat), 12'(exLat));
      chk(12'(flg[3]), 12'(md));
      chk(12'(flg[2]), 12'(wr));
      chk(12'(flg[1:0]), 12'h003);
      if (!wr) begin
        chk(12'(rd), 12'(seed[23:16]));
      end
    end
    repeat (4) @(posedge clk);
    chk(12'(expQ.size()), 12'h000);
    close_out();
  end
endmodule // test_sync_microprocessor_port

`default_nettype wire
